// file: afp_ctrl.sv
// Purpose: protection, fault notification and retry sequencing for the amplifier
// Assumes: guard and supply inputs synchronous to i_clock; i_rst is power-on reset
// Notes:   register port is a simple strobe interface behind the serial control bus
`timescale 1ns/1ns
module afp_ctrl
  import afp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_strap_in,
  output logic             o_fault_out,
  output logic             o_fault_oe_n,
  output logic [6:0]       o_bus_address,
  input  wire logic        i_parallel_bridge_select,
  input  wire logic [3:0]  i_overcurrent_guard,
  input  wire logic        i_overtemp,
  input  wire logic        i_power_stage_supply_good,
  input  wire logic        i_analog_supply_good,
  input  wire logic [7:0]  i_soft_start_timing,
  input  wire logic        i_reg_we,
  input  wire logic        i_reg_re,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  output logic [3:0]       o_bridge_enable,
  output logic [7:0]       o_duty,
  output logic [31:0]      o_routing_mux,
  output logic             o_playing
);
  afp_state_type   state_reg;
  afp_state_type   state_next;
  afp_fault_type   fault;
  afp_reg_req_type req;
  logic [3:0]  settle_reg;
  logic [3:0]  settle_next;
  logic [6:0]  addr_reg;
  logic [6:0]  addr_next;
  logic [7:0]  err_reg;
  logic [7:0]  err_next;
  logic [7:0]  delay_reg;
  logic [7:0]  delay_next;
  logic [31:0] mux_reg;
  logic [31:0] mux_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [3:0]  oc_off_reg;
  logic [3:0]  oc_off_next;
  logic [3:0]  oc_pair;
  logic        uv_now;
  logic        any_fault;
  logic        load_retry;
  logic        retry_done;
  logic [7:0]  duty_raw;

  // ****************************************
  // fault gathering
  // ****************************************
  assign req   = '{we: i_reg_we, re: i_reg_re, addr: i_reg_addr, wdata: i_reg_wdata};
  assign uv_now = !i_power_stage_supply_good || !i_analog_supply_good;
  assign fault = '{oc: i_overcurrent_guard, ot: i_overtemp, uv: uv_now};
  assign any_fault = |fault.oc || fault.ot || fault.uv;

  // pair coupling when parallel-bridge select is high, low by default
  always_comb begin
    oc_pair = fault.oc;
    if (i_parallel_bridge_select) begin
      oc_pair[1:0] = {2{|fault.oc[1:0]}};
      oc_pair[3:2] = {2{|fault.oc[3:2]}};
    end
  end

  // ****************************************
  // sequencer and registers
  // ****************************************
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    addr_next   = addr_reg;
    err_next    = err_reg;
    delay_next  = delay_reg;
    mux_next    = mux_reg;
    rdata_next  = rdata_reg;
    oc_off_next = oc_off_reg;
    load_retry  = 1'b0;
    unique case (state_reg)
      ST_STRAP: begin
        settle_next = settle_reg + 4'h1;
        if (settle_reg == STRAP_SETTLE_CYC) begin
          addr_next  = i_strap_in ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_fault) begin
          state_next  = ST_PROTECT;
          load_retry  = 1'b1;
          oc_off_next = oc_pair;
        end
      end
      ST_PROTECT: begin
        oc_off_next = oc_off_reg | oc_pair;
        if (retry_done) begin
          if (any_fault) begin
            load_retry = 1'b1;
          end else begin
            state_next  = ST_RUN;
            oc_off_next = 4'h0;
          end
        end
      end
      default: state_next = ST_STRAP;
    endcase
    if (req.we) begin
      unique case (req.addr)
        OFF_ERROR_STATUS: err_next = req.wdata[7:0];
        OFF_RETRY_DELAY:  delay_next = req.wdata[7:0];
        OFF_ROUTING_MUX:  mux_next = req.wdata;
        default: ;
      endcase
    end
    if (state_reg != ST_STRAP) begin
      // hardware set wins over host clear
      if (|fault.oc) err_next[BIT_ERR_OC] = 1'b1;
      if (fault.ot)  err_next[BIT_ERR_OT] = 1'b1;
      if (fault.uv)  err_next[BIT_ERR_UV] = 1'b1;
    end
    if (req.re) begin
      unique case (req.addr)
        OFF_ERROR_STATUS: rdata_next = {24'h000000, err_reg};
        OFF_RETRY_DELAY:  rdata_next = {24'h000000, delay_reg};
        OFF_ROUTING_MUX:  rdata_next = mux_reg;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg  <= ST_STRAP;
      settle_reg <= 4'h0;
      addr_reg   <= ADDR_STRAP_LOW;
      err_reg    <= RST_ERROR_STATUS;
      delay_reg  <= RST_RETRY_DELAY;
      mux_reg    <= RST_ROUTING_MUX;
      rdata_reg  <= 32'h0000_0000;
      oc_off_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
      addr_reg   <= addr_next;
      err_reg    <= err_next;
      delay_reg  <= delay_next;
      mux_reg    <= mux_next;
      rdata_reg  <= rdata_next;
      oc_off_reg <= oc_off_next;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  afp_retry_timer u_retry (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (load_retry),
    .i_delay (delay_reg),
    .o_done  (retry_done)
  );

  afp_soft_start u_ramp (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_enable      (o_playing),
    .i_step_cycles (i_soft_start_timing),
    .o_duty        (duty_raw)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign o_playing = state_reg == ST_RUN && !any_fault;
  // any overcurrent stops every half-bridge
  assign o_bridge_enable = o_playing ? 4'hf : 4'h0;
  assign o_duty = duty_raw;
  assign o_routing_mux = mux_reg;
  assign o_bus_address = addr_reg;
  assign o_reg_rdata = rdata_reg;
  assign o_fault_out = 1'b0;
  // pin released during strap, pulled low on fault or latched status
  assign o_fault_oe_n = state_reg == ST_STRAP ? 1'b1 :
                        !(any_fault || err_reg[2:0] != 3'h0);

  // ****************************************
  // checks
  // ****************************************
  AST_FAULT_PIN_NOW: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg != ST_STRAP && any_fault |-> !o_fault_oe_n)
    else $error("fault pin not driven on error");
  AST_FAULT_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg != ST_STRAP && err_reg[2:0] != 3'h0 |-> !o_fault_oe_n)
    else $error("fault pin released before clear");
  AST_STRAP_LATCH: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == ST_STRAP && state_next == ST_RUN |=>
      o_bus_address == ($past(i_strap_in) ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW))
    else $error("address not taken from strap");
  AST_ADDR_STABLE: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg != ST_STRAP |=> $stable(o_bus_address))
    else $error("address changed after power-up");
  AST_ENTER_PROTECT: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == ST_RUN && any_fault |=> state_reg == ST_PROTECT)
    else $error("protection not entered");
  AST_RETRY_AGAIN: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == ST_PROTECT && retry_done && any_fault |=> state_reg == ST_PROTECT)
    else $error("retry left protection with fault");
  AST_RETRY_RESUME: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == ST_PROTECT && retry_done && !any_fault |=> state_reg == ST_RUN)
    else $error("retry did not resume");
  AST_HIZ_ALL: assert property (@(posedge i_clock) disable iff (i_rst)
    (|fault.oc || fault.ot || fault.uv) |-> o_bridge_enable == 4'h0)
    else $error("bridge left on during fault");
  AST_PROTECT_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    state_reg == ST_PROTECT && !retry_done |=> state_reg == ST_PROTECT)
    else $error("protection left before retry point");
endmodule

// file: afp_host_model.sv
// Purpose: host-side model of the address/fault pin and its pull resistor
// Assumes: open-drain pin, resistor sets the level whenever released
// Notes:   the bench plays the host register traffic
`timescale 1ns/1ns
module afp_host_model (
  input  wire logic i_strap_level,
  input  wire logic i_fault_out,
  input  wire logic i_fault_oe_n,
  output logic      o_pin
);
  // ****************************************
  // pin resolution
  // ****************************************
  // released pin shows the pull level, driven pin shows the device value
  assign o_pin = i_fault_oe_n ? i_strap_level : i_fault_out;
endmodule

// file: afp_pkg.sv
// Purpose: shared constants and types for the amplifier fault protection block
// Assumes: single 10 MHz clock, asynchronous active-high reset
// Notes:   register offsets follow the control-bus map
package afp_pkg;
  localparam logic [6:0]  ADDR_STRAP_HIGH   = 7'h1b;
  localparam logic [6:0]  ADDR_STRAP_LOW    = 7'h1a;
  localparam logic [7:0]  OFF_ERROR_STATUS  = 8'h02;
  localparam logic [7:0]  OFF_RETRY_DELAY   = 8'h1c;
  localparam logic [7:0]  OFF_ROUTING_MUX   = 8'h25;
  localparam logic [7:0]  RST_ERROR_STATUS  = 8'h00;
  localparam logic [7:0]  RST_RETRY_DELAY   = 8'h00;
  localparam logic [31:0] RST_ROUTING_MUX   = 32'h0000_0000;
  localparam logic [31:0] PARALLEL_BRIDGE_SELECT_ROUTING_MUX  = 32'h0110_3245;
  localparam int          BIT_ERR_OC        = 0;
  localparam int          BIT_ERR_OT        = 1;
  localparam int          BIT_ERR_UV        = 2;
  localparam int          RETRY_UNIT_NS     = 100000;
  localparam int          CLOCK_NS          = 100;
  localparam logic [15:0] RETRY_UNIT_CYC    = 16'((RETRY_UNIT_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [7:0]  DUTY_FULL         = 8'hff;
  localparam int          STRAP_SETTLE_NS   = 1000;
  localparam logic [3:0]  STRAP_SETTLE_CYC  = 4'((STRAP_SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS);

  typedef enum logic [1:0] {
    ST_STRAP,
    ST_RUN,
    ST_PROTECT
  } afp_state_type;

  typedef struct packed {
    logic [3:0] oc;
    logic       ot;
    logic       uv;
  } afp_fault_type;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [31:0] wdata;
  } afp_reg_req_type;
endpackage

// file: afp_retry_timer.sv
// Purpose: retry interval counter for the protection sequencer
// Assumes: load pulse while entering protection
// Notes:   delay of zero gives a single unit
`timescale 1ns/1ns
module afp_retry_timer
  import afp_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_delay,
  output logic            o_done
);
  logic [15:0] unit_reg;
  logic [15:0] unit_next;
  logic [7:0]  units_reg;
  logic [7:0]  units_next;
  logic        busy_reg;
  logic        busy_next;

  // ****************************************
  // counting
  // ****************************************
  always_comb begin
    unit_next  = unit_reg;
    units_next = units_reg;
    busy_next  = busy_reg;
    if (i_load) begin
      unit_next  = RETRY_UNIT_CYC - 16'h0001;
      units_next = i_delay;
      busy_next  = 1'b1;
    end else if (busy_reg) begin
      if (unit_reg != 16'h0000) begin
        unit_next = unit_reg - 16'h0001;
      end else if (units_reg != 8'h00) begin
        unit_next  = RETRY_UNIT_CYC - 16'h0001;
        units_next = units_reg - 8'h01;
      end else begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      unit_reg  <= 16'h0000;
      units_reg <= 8'h00;
      busy_reg  <= 1'b0;
    end else begin
      unit_reg  <= unit_next;
      units_reg <= units_next;
      busy_reg  <= busy_next;
    end
  end

  // done is taken from registers only, so a reload at the retry point cannot loop back
  assign o_done = busy_reg && unit_reg == 16'h0000 && units_reg == 8'h00;

  AST_RETRY_LOAD: assert property (@(posedge i_clock) disable iff (i_rst)
    i_load |=> busy_reg && unit_reg == RETRY_UNIT_CYC - 16'h0001)
    else $error("retry timer not loaded");
endmodule

// file: afp_soft_start.sv
// Purpose: duty ramp on leaving all-channel shutdown
// Assumes: soft-start timing input plus one gives cycles per step
// Notes:   ramp restarts from zero on every shutdown
`timescale 1ns/1ns
module afp_soft_start
  import afp_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [7:0] i_step_cycles,
  output logic [7:0]      o_duty
);
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [7:0] tick_reg;
  logic [7:0] tick_next;

  // ****************************************
  // ramp
  // ****************************************
  always_comb begin
    duty_next = duty_reg;
    tick_next = tick_reg;
    if (!i_enable) begin
      duty_next = 8'h00;
      tick_next = 8'h00;
    end else if (duty_reg != DUTY_FULL) begin
      if (tick_reg >= i_step_cycles) begin
        tick_next = 8'h00;
        duty_next = duty_reg + 8'h01;
      end else begin
        tick_next = tick_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      duty_reg <= 8'h00;
      tick_reg <= 8'h00;
    end else begin
      duty_reg <= duty_next;
      tick_reg <= tick_next;
    end
  end

  assign o_duty = duty_reg;

  AST_RAMP_STEP: assert property (@(posedge i_clock) disable iff (i_rst)
    i_enable && $past(i_enable) |-> o_duty - $past(o_duty) <= 8'h01)
    else $error("duty ramp jumped");
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the amplifier fault protection block
// Assumes: retry delay register set to 1, soft-start step every 4 cycles
// Notes:   run is about 10000 cycles
`timescale 1ns/1ns
module testbench;
  import afp_pkg::*;
  logic        i_clock  = 1'b0;
  logic        i_rst    = 1'b1;
  logic        strap    = 1'b0;
  logic        pin;
  logic        f_out;
  logic        f_oe_n;
  logic [6:0]  bus_addr;
  logic        pbs      = 1'b0;
  logic [3:0]  oc       = 4'h0;
  logic        ot       = 1'b0;
  logic        ps_good  = 1'b1;
  logic        an_good  = 1'b1;
  logic [7:0]  ss_time  = 8'h03;
  logic        we       = 1'b0;
  logic        re       = 1'b0;
  logic [7:0]  addr     = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic [31:0] rdata;
  logic [3:0]  br_en;
  logic [7:0]  duty;
  logic [31:0] mux;
  logic        playing;
  int          err_total  = 0;
  int          n_compared = 0;

  always #50 i_clock = ~i_clock;

  afp_host_model host (.i_strap_level(strap), .i_fault_out(f_out), .i_fault_oe_n(f_oe_n),
                       .o_pin(pin));
  afp_ctrl dut (.i_clock(i_clock), .i_rst(i_rst), .i_strap_in(pin), .o_fault_out(f_out),
                .o_fault_oe_n(f_oe_n), .o_bus_address(bus_addr),
                .i_parallel_bridge_select(pbs), .i_overcurrent_guard(oc), .i_overtemp(ot),
                .i_power_stage_supply_good(ps_good), .i_analog_supply_good(an_good),
                .i_soft_start_timing(ss_time), .i_reg_we(we), .i_reg_re(re),
                .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
                .o_bridge_enable(br_en), .o_duty(duty), .o_routing_mux(mux),
                .o_playing(playing));

  // ****************************************
  // tasks
  // ****************************************
  task conclude;
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task do_reset(input logic lvl);
    @(posedge i_clock);
    strap <= lvl;
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 chk({28'h0, br_en, duty}, 32'h0);
    @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (14) @(posedge i_clock);
    strap <= ~lvl;
    repeat (3) @(posedge i_clock);
    #1 chk({25'h0, bus_addr}, {25'h0, lvl ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW});
    @(posedge i_clock);
    strap <= lvl;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    we <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    re <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    re <= 1'b0;
    @(posedge i_clock);
    #1 chk(rdata, exp);
  endtask

  task wait_retry(input int quiet);
    int i;
    repeat (quiet) @(posedge i_clock);
    #1 chk({31'h0, playing}, 32'h0);
    i = 0;
    while (playing !== 1'b1 && i < 2100) begin
      @(posedge i_clock);
      #1 i++;
    end
    chk({31'h0, playing}, 32'h1);
    chk({28'h0, br_en}, 32'hf);
    chk({31'h0, duty < 8'h04}, 32'h1);
  endtask

  task fault_edge;
    #1 chk({27'h0, br_en, pin}, 32'h0);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    rd(OFF_ERROR_STATUS, {24'h0, RST_ERROR_STATUS});
    rd(OFF_RETRY_DELAY, {24'h0, RST_RETRY_DELAY});
    rd(OFF_ROUTING_MUX, RST_ROUTING_MUX);
    wr(8'h7f, 32'hffff_ffff);
    rd(8'h7f, 32'h0);
    wr(OFF_ROUTING_MUX, PARALLEL_BRIDGE_SELECT_ROUTING_MUX);
    rd(OFF_ROUTING_MUX, PARALLEL_BRIDGE_SELECT_ROUTING_MUX);
    chk(mux, PARALLEL_BRIDGE_SELECT_ROUTING_MUX);
    wr(OFF_RETRY_DELAY, 32'h1);
    rd(OFF_RETRY_DELAY, 32'h1);
    chk({31'h0, pin}, 32'h1);
    @(posedge i_clock);
    oc <= 4'h1;
    fault_edge;
    @(posedge i_clock);
    oc <= 4'h0;
    rd(OFF_ERROR_STATUS, 32'h1);
    wait_retry(1970);
    repeat (40) @(posedge i_clock);
    #1 chk({31'h0, duty > 8'h05 && duty < 8'h10}, 32'h1);
    chk({31'h0, pin}, 32'h0);
    wr(OFF_ERROR_STATUS, 32'h0);
    @(posedge i_clock);
    #1 chk({31'h0, pin}, 32'h1);
    @(posedge i_clock);
    ot <= 1'b1;
    fault_edge;
    repeat (2200) @(posedge i_clock);
    #1 chk({31'h0, playing}, 32'h0);
    @(posedge i_clock);
    ot <= 1'b0;
    wait_retry(1690);
    wr(OFF_ERROR_STATUS, 32'h0);
    @(posedge i_clock);
    an_good <= 1'b0;
    fault_edge;
    @(posedge i_clock);
    an_good <= 1'b1;
    ps_good <= 1'b0;
    fault_edge;
    @(posedge i_clock);
    ps_good <= 1'b1;
    rd(OFF_ERROR_STATUS, 32'h4);
    wait_retry(1970);
    wr(OFF_ERROR_STATUS, 32'h0);
    @(posedge i_clock);
    pbs <= 1'b1;
    oc <= 4'h4;
    fault_edge;
    @(posedge i_clock);
    oc <= 4'h0;
    wait_retry(1970);
    conclude;
  end

  initial begin
    #3_000_000;
    err_total++;
    conclude;
  end
endmodule
